/* File: rtl/hbmsp_pkg.sv */
// constants and types shared by the host bus mode select port
package hbmsp_pkg;

    // **********************************************************************
    // interface modes
    // **********************************************************************
    typedef enum logic [2:0] {
        HBMSP_MODE_6800,
        HBMSP_MODE_8080,
        HBMSP_MODE_SPI4,
        HBMSP_MODE_SPI3,
        HBMSP_MODE_I2C,
        HBMSP_MODE_NONE
    } hbmsp_mode_t;

    // **********************************************************************
    // strap codes, written as {pin0, pin1, pin2}
    // **********************************************************************
    localparam logic [2:0] HBMSP_STRAP_6800 = 3'h1;
    localparam logic [2:0] HBMSP_STRAP_8080 = 3'h3;
    localparam logic [2:0] HBMSP_STRAP_SPI4 = 3'h0;
    localparam logic [2:0] HBMSP_STRAP_SPI3 = 3'h4;
    localparam logic [2:0] HBMSP_STRAP_I2C  = 3'h2;

    // **********************************************************************
    // widths, pin positions and reset values
    // **********************************************************************
    localparam int         HBMSP_DATA_W     = 8;
    localparam int         HBMSP_SYNC_W     = 13;
    localparam int         HBMSP_SCL_BIT    = 0;
    localparam int         HBMSP_SDI_BIT    = 1;
    localparam logic [7:0] HBMSP_BYTE_RST   = 8'h00;
    localparam logic [7:0] HBMSP_HIZ_MASK   = 8'hFC;
    localparam logic [7:0] HBMSP_ALL_OE     = 8'hFF;
    localparam logic [7:0] HBMSP_NO_OE      = 8'h00;

endpackage : hbmsp_pkg

/* File: rtl/hbmsp_sync.sv */
// two flip-flop synchroniser for a vector of pin levels
`timescale 1ns/10ps
module hbmsp_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clock,
    input  wire logic         reset,
    // levels
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_q;

    // meta_q is read only by the second stage
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            meta_q   <= '0;
            sync_out <= '0;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule : hbmsp_sync

/* File: rtl/hbmsp_port.sv */
// host bus mode select port: strap decode, pin roles and data direction
`timescale 1ns/10ps
module hbmsp_port
    import hbmsp_pkg::*;
#(
    parameter int DW = HBMSP_DATA_W
) (
    // clock and reset
    input  wire logic          clock,
    input  wire logic          reset,
    input  wire logic          reset_n,
    // strap pins
    input  wire logic          bus_select_pin0,
    input  wire logic          bus_select_pin1,
    input  wire logic          bus_select_pin2,
    // host control pins
    input  wire logic          chip_select_n,
    input  wire logic          data_command_select,
    input  wire logic          write_strobe_pin,
    input  wire logic          read_strobe_pin,
    // data pins
    input  wire logic [DW-1:0] data_in,
    output logic      [DW-1:0] data_out,
    output logic      [DW-1:0] data_oe,
    // core side: read data, written bytes, mode and serial lines
    input  wire logic [DW-1:0] read_data,
    output logic               read_req_q,
    output logic      [DW-1:0] write_byte_q,
    output logic               write_is_data_q,
    output logic               write_valid_q,
    output hbmsp_mode_t        mode_q,
    output logic               serial_clock_q,
    output logic               serial_data_q,
    output logic               i2c_data_in,
    output logic               slave_address_low_bit
);
    // **********************************************************************
    // input synchronisation
    // **********************************************************************
    logic [HBMSP_SYNC_W-1:0] raw_w;
    logic [HBMSP_SYNC_W-1:0] syn_w;
    assign raw_w = {reset_n, chip_select_n, data_command_select, write_strobe_pin,
                    read_strobe_pin, data_in};

    hbmsp_sync #(.W(HBMSP_SYNC_W)) u_sync (
        .clock    (clock),
        .reset    (reset),
        .async_in (raw_w),
        .sync_out (syn_w)
    );

    logic          rst_n_s, cs_n_s, dc_s, wr_s, rd_s;
    logic [DW-1:0] d_s;
    assign {rst_n_s, cs_n_s, dc_s, wr_s, rd_s, d_s} = syn_w;

    // **********************************************************************
    // strap decode
    // **********************************************************************
    function automatic hbmsp_mode_t decode_strap(input logic [2:0] s);
        hbmsp_mode_t m;
        m = HBMSP_MODE_NONE;
        if (s == HBMSP_STRAP_6800) begin
            m = HBMSP_MODE_6800;
        end else if (s == HBMSP_STRAP_8080) begin
            m = HBMSP_MODE_8080;
        end else if (s == HBMSP_STRAP_SPI4) begin
            m = HBMSP_MODE_SPI4;
        end else if (s == HBMSP_STRAP_SPI3) begin
            m = HBMSP_MODE_SPI3;
        end else if (s == HBMSP_STRAP_I2C) begin
            m = HBMSP_MODE_I2C;
        end
        return m;
    endfunction : decode_strap

    // straps are static, but still pass the synchroniser pair
    logic [2:0] strap_meta_q;
    logic [2:0] strap_q;
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            strap_meta_q <= 3'h0;
            strap_q      <= 3'h0;
        end else begin
            strap_meta_q <= {bus_select_pin0, bus_select_pin1, bus_select_pin2};
            strap_q      <= strap_meta_q;
        end
    end

    // settings reload while the pin reset is low; a strap change made later
    // has no effect until the next pin reset, so a live bus never switches roles
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            mode_q <= HBMSP_MODE_NONE;
        end else if (!rst_n_s) begin
            mode_q <= decode_strap(strap_q);
        end
    end

    // **********************************************************************
    // pin roles
    // **********************************************************************
    wire is_8080   = (mode_q == HBMSP_MODE_8080);
    wire is_6800   = (mode_q == HBMSP_MODE_6800);
    wire is_i2c    = (mode_q == HBMSP_MODE_I2C);
    wire is_serial = (mode_q == HBMSP_MODE_SPI4) || (mode_q == HBMSP_MODE_SPI3);
    wire sel       = !cs_n_s && rst_n_s;
    // 8080: read strobe low requests a read
    wire rd_8080   = is_8080 && sel && !rd_s;
    // 6800: enable high with r/w high is a read
    wire rd_6800   = is_6800 && sel && rd_s && wr_s;
    wire drive_w   = rd_8080 || rd_6800;

    // **********************************************************************
    // write capture
    // **********************************************************************
    logic wr_prev_q, rd_prev_q;
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            wr_prev_q <= 1'b1;
            rd_prev_q <= 1'b0;
        end else begin
            wr_prev_q <= wr_s;
            rd_prev_q <= rd_s;
        end
    end
    // the data bits travel through the same two stages as the strobes
    wire wr_8080_w = is_8080 && sel && wr_s && !wr_prev_q;
    // 6800 write latches at the falling edge of enable with r/w low
    wire wr_6800_w = is_6800 && sel && !rd_s && rd_prev_q && !wr_s;
    wire wr_take_w = wr_8080_w || wr_6800_w;

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            write_byte_q    <= HBMSP_BYTE_RST;
            write_is_data_q <= 1'b0;
            write_valid_q   <= 1'b0;
        end else begin
            write_valid_q <= wr_take_w;
            if (wr_take_w) begin
                write_byte_q    <= d_s;
                write_is_data_q <= dc_s;
            end
        end
    end

    // **********************************************************************
    // data pin drivers and serial lines
    // **********************************************************************
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            data_out              <= HBMSP_BYTE_RST;
            data_oe               <= HBMSP_NO_OE;
            read_req_q            <= 1'b0;
            serial_clock_q        <= 1'b0;
            serial_data_q         <= 1'b0;
            i2c_data_in           <= 1'b0;
            slave_address_low_bit <= 1'b0;
        end else begin
            data_out   <= drive_w ? read_data : HBMSP_BYTE_RST;
            // serial and I2C never drive; pins 2-7 stay undriven
            data_oe    <= drive_w ? HBMSP_ALL_OE : HBMSP_NO_OE;
            read_req_q <= drive_w;
            serial_clock_q        <= (is_serial || is_i2c) && d_s[HBMSP_SCL_BIT];
            serial_data_q         <= is_serial && d_s[HBMSP_SDI_BIT];
            i2c_data_in           <= is_i2c && d_s[HBMSP_SDI_BIT];
            slave_address_low_bit <= is_i2c && dc_s;
        end
    end

    // **********************************************************************
    // assertions
    // **********************************************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    a_oe_8080_read: assert property (rd_8080 |=> data_oe == HBMSP_ALL_OE)
        else $error("8080 read did not enable data drivers");
    a_oe_8080_idle: assert property (is_8080 && rd_s |=> data_oe == HBMSP_NO_OE)
        else $error("8080 drives data with read strobe high");
    a_oe_6800_en: assert property (is_6800 && !rd_s |=> data_oe == HBMSP_NO_OE)
        else $error("6800 drives data with enable low");
    a_oe_6800_rw: assert property (is_6800 && !wr_s |=> data_oe == HBMSP_NO_OE)
        else $error("6800 drives data during write");
    a_width_oe: assert property (data_oe == HBMSP_ALL_OE || data_oe == HBMSP_NO_OE)
        else $error("partial data drive");
    a_serial_hiz: assert property (is_serial |=> (data_oe & HBMSP_HIZ_MASK) == HBMSP_NO_OE)
        else $error("serial mode drives pins 2-7");
    a_i2c_hiz: assert property (is_i2c |=> (data_oe & HBMSP_HIZ_MASK) == HBMSP_NO_OE)
        else $error("i2c mode drives pins 2-7");
    a_wr_capture: assert property (wr_8080_w |=> write_valid_q && write_byte_q == $past(d_s))
        else $error("8080 write byte not captured");
    a_dc_flag: assert property (wr_take_w |=> write_is_data_q == $past(dc_s))
        else $error("data/command flag wrong");
    a_sa0_map: assert property (is_i2c ##1 is_i2c |-> slave_address_low_bit == $past(dc_s))
        else $error("slave address bit wrong");
    a_mode_strap: assert property (!rst_n_s |=> mode_q == decode_strap($past(strap_q)))
        else $error("mode does not follow straps");
    a_mode_hold: assert property (rst_n_s |=> mode_q == $past(mode_q))
        else $error("mode changed outside pin reset");
    a_wr6800_capture: assert property (wr_6800_w |=> write_valid_q && write_byte_q == $past(d_s))
        else $error("6800 write byte not captured");
    // the serial outputs must read zero outside their own modes
    a_spi_lines_idle: assert property (!is_serial |=> !serial_data_q)
        else $error("serial data seen outside serial modes");
    a_i2c_lines_idle: assert property (!is_i2c |=> !i2c_data_in && !slave_address_low_bit)
        else $error("i2c lines seen outside i2c mode");

    c_read_8080:  cover property (rd_8080 ##1 data_oe == HBMSP_ALL_OE);
    c_write_8080: cover property (wr_8080_w ##1 write_valid_q);
    c_write_6800: cover property (wr_6800_w);
    c_i2c_mode:   cover property (is_i2c && serial_clock_q);
    c_read_6800:  cover property (rd_6800 ##1 data_oe == HBMSP_ALL_OE);
endmodule : hbmsp_port

/* File: dv/hbmsp_host_model.sv */
// host model that drives the strobes and the shared data wires of the port
`timescale 1ns/10ps
module hbmsp_host_model (
    // clock
    input  wire logic       clock,
    // data wires seen from the port
    input  wire logic [7:0] data_out,
    input  wire logic [7:0] data_oe,
    output logic      [7:0] data_in,
    // control pins
    output logic            chip_select_n,
    output logic            data_command_select,
    output logic            write_strobe_pin,
    output logic            read_strobe_pin
);
    logic [7:0] drv_q;
    logic [7:0] last_q = 8'h5A;
    logic       drive;
    // a released wire flips every cycle, so a stale level never passes as data
    always_comb for (int i = 0; i < 8; i++) data_in[i] = data_oe[i] ? data_out[i] :
        (drive ? drv_q[i] : last_q[i]);
    always @(posedge clock) last_q <= ~last_q;
    initial begin
        {drv_q, drive, chip_select_n, data_command_select} = {8'h00, 3'h2};
        {write_strobe_pin, read_strobe_pin} = 2'h3;
    end
    task automatic idle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : idle
    task automatic park(input logic w, input logic r);
        write_strobe_pin = w;
        read_strobe_pin  = r;
    endtask : park
    task automatic put(input logic [7:0] v, input logic dc, input logic on);
        {drv_q, data_command_select, drive} = {v, dc, on};
    endtask : put
    // a six-clock phase before and a four-clock phase after keep data steady around the sampled strobe edge
    task automatic xfer(input logic m68, input logic rd, input logic [7:0] b,
                        input logic dc, input logic cs_n,
                        output logic [7:0] got, output logic [7:0] oe);
        put(b, dc, !rd);
        chip_select_n = cs_n;
        if (m68) park(rd, 1'b1);
        else if (rd) read_strobe_pin = 1'b0;
        else write_strobe_pin = 1'b0;
        idle(6);
        got = data_in;
        oe  = data_oe;
        if (m68) read_strobe_pin = 1'b0;
        else park(1'b1, 1'b1);
        idle(4);
        drive = 1'b0;
        chip_select_n = 1'b1;
        // chip select stays high across edges before the next transfer
        idle(2);
    endtask : xfer
endmodule : hbmsp_host_model

/* File: dv/tb_top.sv */
// self-checking bench for the host bus mode select port
`timescale 1ns/10ps
module tb_top;
    import hbmsp_pkg::*;
    logic        clock = 0, reset = 1, reset_n = 0, cs_n, dc, wr, rd;
    logic        read_req_q, valid, is_data, sclk, sdat, sda, sa0;
    logic [2:0]  strap = 3'h0;
    logic [7:0]  read_data = 8'h00, data_in, data_out, data_oe, wbyte, got, oe;
    logic [7:0]  exp_b, exp_n, n_valid, n_req, exp_r, wb;
    logic        exp_dc, b, c, p;
    hbmsp_mode_t mode, m;
    int          n_mismatch = 0, n_checks = 0, seed;
    logic [2:0]  codes [6] = '{3'h5, 3'h0, 3'h4, 3'h2, 3'h1, 3'h3};
    hbmsp_port dut (.clock(clock), .reset(reset), .reset_n(reset_n),
        .bus_select_pin0(strap[2]), .bus_select_pin1(strap[1]), .bus_select_pin2(strap[0]),
        .chip_select_n(cs_n), .data_command_select(dc), .write_strobe_pin(wr),
        .read_strobe_pin(rd), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
        .read_data(read_data), .read_req_q(read_req_q), .write_byte_q(wbyte),
        .write_is_data_q(is_data), .write_valid_q(valid), .mode_q(mode),
        .serial_clock_q(sclk), .serial_data_q(sdat), .i2c_data_in(sda),
        .slave_address_low_bit(sa0));
    hbmsp_host_model host (.clock(clock), .data_out(data_out), .data_oe(data_oe),
        .data_in(data_in), .chip_select_n(cs_n), .data_command_select(dc),
        .write_strobe_pin(wr), .read_strobe_pin(rd));
    initial forever #2 clock = ~clock;
    always @(posedge clock) n_valid <= reset ? 8'h00 : n_valid + {7'h00, valid === 1'b1};
    always @(posedge clock) n_req <= reset ? 8'h00 : n_req + {7'h00, read_req_q === 1'b1};
    function automatic hbmsp_mode_t exp_mode(input logic [2:0] s);
        case (s)
            HBMSP_STRAP_6800: return HBMSP_MODE_6800;
            HBMSP_STRAP_8080: return HBMSP_MODE_8080;
            HBMSP_STRAP_SPI4: return HBMSP_MODE_SPI4;
            HBMSP_STRAP_SPI3: return HBMSP_MODE_SPI3;
            HBMSP_STRAP_I2C:  return HBMSP_MODE_I2C;
            default:          return HBMSP_MODE_NONE;
        endcase
    endfunction : exp_mode
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            $display("BAD %s expected %h seen %h", nm, e, g);
            n_mismatch++;
        end
    endtask : chk
    task automatic chk_bit(input string nm, input logic e, input logic g);
        n_checks++;
        if (g !== e) begin
            $display("BAD %s expected %b seen %b", nm, e, g);
            n_mismatch++;
        end
    endtask : chk_bit
    task automatic chk_mode(input hbmsp_mode_t e, input hbmsp_mode_t g);
        n_checks++;
        if (g !== e) begin
            $display("BAD mode_q expected %0d seen %0d", e, g);
            n_mismatch++;
        end
    endtask : chk_mode
    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : close_out
    initial begin
        #100000;
        n_mismatch++;
        close_out;
    end
    initial begin
        seed = 34;
        {exp_b, exp_dc, exp_n, exp_r} = {8'h00, 1'b0, 8'h00, 8'h00};
        host.idle(2);
        reset = 0;
        foreach (codes[i]) begin
            m = exp_mode(codes[i]);
            strap = codes[i];
            reset_n = 0;
            if (m inside {HBMSP_MODE_SPI4, HBMSP_MODE_SPI3, HBMSP_MODE_I2C})
                host.park(1'b0, 1'b0);
            else host.park(1'b1, m != HBMSP_MODE_6800);
            host.idle(8);
            reset_n = 1;
            host.idle(4);
            chk_mode(m, mode);
            // link clock of 48 ns: six clocks low then six high per bit
            if (m inside {HBMSP_MODE_SPI4, HBMSP_MODE_SPI3, HBMSP_MODE_I2C}) begin
                for (int k = 0; k < 16; k++) begin
                    b = (k % 2 == 0) ? 1'($random(seed)) : b;
                    c = 1'($random(seed));
                    host.put({6'h2A, b, k[0]}, c, 1'b1);
                    host.idle(6);
                    chk_bit("sclk", k[0], sclk);
                    chk_bit("sdi", (m == HBMSP_MODE_I2C) ? 1'b0 : b, sdat);
                    chk_bit("sda", (m == HBMSP_MODE_I2C) ? b : 1'b0, sda);
                    chk_bit("sa0", (m == HBMSP_MODE_I2C) ? c : 1'b0, sa0);
                    chk("oe_ser", HBMSP_NO_OE, data_oe);
                end
                host.put(8'h00, 1'b0, 1'b1);
            end
            if (m inside {HBMSP_MODE_6800, HBMSP_MODE_8080}) begin
                p = m == HBMSP_MODE_6800;
                for (int k = 0; k < 6; k++) begin
                    b = k == 5;
                    c = 1'($random(seed));
                    wb = (k == 0) ? 8'hFF : (k == 1) ? 8'h00 : 8'($random(seed));
                    read_data = 8'($random(seed));
                    host.xfer(p, 1'b0, wb, c, b, got, oe);
                    if (!b) {exp_b, exp_dc, exp_n} = {wb, c, exp_n + 8'h01};
                    chk("oe_write", HBMSP_NO_OE, oe);
                    chk("byte", exp_b, wbyte);
                    chk_bit("dc_flag", exp_dc, is_data);
                    chk("valid_count", exp_n, n_valid);
                    host.xfer(p, 1'b1, 8'h00, 1'b0, 1'b0, got, oe);
                    // the read strobe phase lasts six clocks, so six request cycles
                    exp_r = exp_r + 8'h06;
                    chk("oe_read", HBMSP_ALL_OE, oe);
                    chk("rd_byte", read_data, got);
                    chk("oe_off", HBMSP_NO_OE, data_oe);
                    chk("req_count", exp_r, n_req);
                end
            end
        end
        close_out;
    end
endmodule : tb_top
